// file: logic/flash_prog_pkg.sv
// constants and carrier types for the flash self-programming controller
package flash_prog_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_ZPTR   = 4'h8;
    localparam logic [3:0] ADR_DATA   = 4'hC;
    localparam int BIT_PEN  = 0;
    localparam int BIT_ERS  = 1;
    localparam int BIT_WRT  = 2;
    localparam int BIT_LRD  = 3;
    localparam int BIT_SRE  = 4;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOAD  = 5'h01;
    localparam logic [4:0] CMD_LREAD = 5'h09;
    localparam logic [4:0] CMD_SRE   = 5'h11;
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW  = 3'h3;
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam int PROG_TIME_US = 4;
    localparam int CLOCK_MHZ    = 200;
    localparam int PROG_CYCLES  = PROG_TIME_US * CLOCK_MHZ;

    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] zptr;
        logic [15:0] data;
    } cpu_req_type;

    typedef struct packed {
        logic [7:0] lock_byte;
        logic [7:0] fuse_low;
        logic [7:0] fuse_high;
        logic [7:0] fuse_ext;
    } fuse_set_type;
endpackage

// file: logic/flash_self_program_control.sv
// flash self-programming sequencer with wishbone register access
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module flash_self_program_control
    import flash_prog_pkg::*;
#(
    parameter int WORD_BITS = 6,
    parameter int PAGE_BITS = 8,
    parameter int PROG_LEN  = PROG_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADDR_W-1:0]     wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire cpu_req_type           cpu_req,
    input  wire logic                  eeprom_write_busy_flag,
    input  wire fuse_set_type          fuses,
    input  wire logic [15:0]           flash_word,
    output logic [7:0]                 load_result,
    output logic                       load_valid,
    output logic                       cpu_stall,
    output logic [WORD_BITS-1:0]       flash_rd_addr,
    output logic                       flash_erase,
    output logic                       flash_write,
    output logic [PAGE_BITS-1:0]       flash_page,
    output logic [15:0]                flash_wr_data,
    output logic [WORD_BITS-1:0]       flash_wr_word
);
    localparam int DEPTH = 1 << WORD_BITS;
    localparam int CW = $clog2(PROG_LEN + 1);
    localparam logic [CW-1:0] PROG_LEN_C = CW'(PROG_LEN);

    typedef enum logic [1:0] {IDLE, ERASING, WRITING, DRAIN} state_type;

    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic sel);
        pick_byte = sel ? w[15:8] : w[7:0];
    endfunction

    state_type state_q, state_d;
    logic [4:0]    prog_control_reg;
    logic [2:0]    arm_cnt_q;
    logic [CW-1:0] busy_cnt_q;
    logic [15:0]   page_buffer [DEPTH];
    logic [DEPTH-1:0] buf_valid_q;
    logic          load_seq_q;
    logic [PAGE_BITS-1:0] page_q;
    logic [WORD_BITS-1:0] drain_idx_q;
    logic          ack_q;
    logic [31:0]   rdata_q;
    logic [7:0]    load_result_q;
    logic          load_valid_q;
    logic          stall_q, erase_q, write_q;
    logic [15:0]   wr_data_q;
    logic [WORD_BITS-1:0] wr_word_q, rd_addr_q;

    wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire ctrl_wr   = bus_req & wb_we_i & (wb_adr_i == ADR_CTRL) & wb_sel_i[0];
    wire [4:0] wcode = wb_dat_i[4:0];
    wire idle      = (state_q == IDLE);
    wire code_ok   = (wcode == CMD_SRE) | (wcode == CMD_LREAD) | (wcode == CMD_WRITE) |
                     (wcode == CMD_LOAD) | (wcode == CMD_ERASE);
    wire accept_wr = ctrl_wr & code_ok & idle & ~eeprom_write_busy_flag;
    wire armed     = prog_control_reg[BIT_PEN] & idle & (arm_cnt_q != 3'h0);
    wire [WORD_BITS-1:0] z_word = cpu_req.zptr[WORD_BITS:1];
    wire [PAGE_BITS-1:0] z_page = cpu_req.zptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    wire is_erase  = armed & cpu_req.store & (prog_control_reg == CMD_ERASE);
    wire is_write  = armed & cpu_req.store & (prog_control_reg == CMD_WRITE);
    wire is_load   = armed & cpu_req.store & (prog_control_reg == CMD_LOAD);
    wire lread_arm = armed & (prog_control_reg == CMD_LREAD) & (arm_cnt_q > 3'h1);
    wire is_fread  = lread_arm & cpu_req.load & ~eeprom_write_busy_flag;
    wire sre_wr    = accept_wr & wcode[BIT_SRE];
    wire busy_done = (busy_cnt_q == CW'(1));
    wire drain_end = (state_q == DRAIN) & (drain_idx_q == WORD_BITS'(DEPTH - 1));
    wire buf_clear = drain_end | sre_wr | (load_seq_q & eeprom_write_busy_flag);
    wire [7:0] fuse_sel = (cpu_req.zptr == Z_LOCK)      ? fuses.lock_byte :
                          (cpu_req.zptr == Z_FUSE_LOW)  ? fuses.fuse_low  :
                          (cpu_req.zptr == Z_FUSE_HIGH) ? fuses.fuse_high :
                          (cpu_req.zptr == Z_FUSE_EXT)  ? fuses.fuse_ext  : 8'hFF;
    wire [7:0] rd_byte = is_fread ? fuse_sel : pick_byte(flash_word, cpu_req.zptr[0]);
    wire [31:0] status_w = {28'h0, load_seq_q, stall_q, ~idle, eeprom_write_busy_flag};
    wire [31:0] rdata_w = (wb_adr_i == ADR_CTRL)   ? {27'h0, prog_control_reg} :
                          (wb_adr_i == ADR_STATUS) ? status_w :
                          (wb_adr_i == ADR_ZPTR)   ? {16'h0, 8'(page_q), 8'h0} : 32'h0;

    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE:    if (is_erase) state_d = ERASING; else if (is_write) state_d = WRITING;
            ERASING: if (busy_done) state_d = IDLE;
            WRITING: if (busy_done) state_d = DRAIN;
            DRAIN:   if (drain_end) state_d = IDLE;
            default: state_d = IDLE;
        endcase
    end

    // the operation and its busy count ignore rst so a started program cycle finishes
    always_ff @(posedge clock) begin
        state_q <= state_d;
        if (is_erase || is_write) busy_cnt_q <= PROG_LEN_C;
        else if (busy_cnt_q != '0) busy_cnt_q <= busy_cnt_q - CW'(1);
        if (is_erase || is_write) page_q <= z_page;
        if (state_q != DRAIN) drain_idx_q <= '0;
        else drain_idx_q <= drain_idx_q + WORD_BITS'(1);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            // a program cycle runs on through reset, so the enable bit keeps flagging it busy
            prog_control_reg <= idle ? 5'h00 : prog_control_reg;
            arm_cnt_q        <= '0;
        end else if (accept_wr) begin
            prog_control_reg <= wcode;
            arm_cnt_q        <= STORE_WINDOW;
        end else if (is_erase || is_write) begin
            prog_control_reg <= prog_control_reg;
            arm_cnt_q        <= '0;
        end else if (!idle) begin
            if (busy_done && state_q == ERASING) prog_control_reg <= '0;
            if (drain_end) prog_control_reg <= '0;
        end else if (is_load || is_fread || (arm_cnt_q == 3'h1) ||
                     (cpu_req.store && prog_control_reg != '0)) begin
            prog_control_reg <= '0;
            arm_cnt_q        <= '0;
        end else if (arm_cnt_q != 3'h0) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (is_load) page_buffer[z_word] <= cpu_req.data;
        if (rst || buf_clear) buf_valid_q <= '0;
        else if (is_load) buf_valid_q[z_word] <= 1'b1;
        if (rst || buf_clear || is_write) load_seq_q <= 1'b0;
        else if (is_load) load_seq_q <= 1'b1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0; rdata_q <= '0; load_valid_q <= 1'b0; load_result_q <= '0;
            stall_q <= 1'b0; erase_q <= 1'b0; write_q <= 1'b0;
            wr_data_q <= '0; wr_word_q <= '0; rd_addr_q <= '0;
        end else begin
            ack_q         <= bus_req;
            rdata_q       <= rdata_w;
            load_valid_q  <= cpu_req.load & (is_fread | ~lread_arm);
            load_result_q <= rd_byte;
            stall_q       <= (state_d != IDLE);
            erase_q       <= is_erase;
            write_q       <= (state_q == DRAIN) & buf_valid_q[drain_idx_q];
            wr_data_q     <= page_buffer[drain_idx_q];
            wr_word_q     <= drain_idx_q;
            rd_addr_q     <= cpu_req.zptr[WORD_BITS:1];
        end
    end

    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = rdata_q;
    assign load_result   = load_result_q;
    assign load_valid    = load_valid_q;
    assign cpu_stall     = stall_q;
    assign flash_erase   = erase_q;
    assign flash_write   = write_q;
    assign flash_page    = page_q;
    assign flash_wr_data = wr_data_q;
    assign flash_wr_word = wr_word_q;
    assign flash_rd_addr = rd_addr_q;

    stall_hold_a: assert property (@(posedge clock) disable iff (rst)
        (is_erase || is_write) |=> ##1 cpu_stall[*3]) else $error("stall not held");
    enable_busy_a: assert property (@(posedge clock) disable iff (rst)
        (state_q != IDLE && !drain_end && !(busy_done && state_q == ERASING))
        |=> prog_control_reg[BIT_PEN]) else $error("enable dropped while busy");
    bad_code_a: assert property (@(posedge clock) disable iff (rst)
        (ctrl_wr && !code_ok && !armed && idle) |=> prog_control_reg == $past(prog_control_reg))
        else $error("bad pattern accepted");
    arm_expire_a: assert property (@(posedge clock) disable iff (rst)
        (accept_wr && !sre_wr) |-> ##[1:5] (prog_control_reg == '0 || !idle))
        else $error("armed command did not expire");
    ee_block_a: assert property (@(posedge clock) disable iff (rst)
        (ctrl_wr && eeprom_write_busy_flag) |-> !accept_wr) else $error("write during eeprom busy");
    sre_clear_a: assert property (@(posedge clock) disable iff (rst)
        sre_wr |=> buf_valid_q == '0) else $error("buffer not cleared");
    fuse_read_a: assert property (@(posedge clock) disable iff (rst)
        (is_fread && cpu_req.zptr == Z_LOCK) |=> load_result == $past(fuses.lock_byte))
        else $error("lock byte wrong");
    plain_read_a: assert property (@(posedge clock) disable iff (rst)
        (cpu_req.load && !lread_arm) |=> load_result == pick_byte($past(flash_word), $past(cpu_req.zptr[0])))
        else $error("plain read wrong");
    erase_cov: cover property (@(posedge clock) is_erase);
    write_cov: cover property (@(posedge clock) drain_end);
    fuse_cov:  cover property (@(posedge clock) is_fread);
endmodule

// file: tb/cpu_core_model.sv
// cpu core model: store and load instruction pulses, program memory and fuse array
`timescale 1ns/1ps
module cpu_core_model
    import flash_prog_pkg::*;
(
    input  wire logic        clock,
    output cpu_req_type      cpu_req,
    output fuse_set_type     fuses,
    output logic [15:0]      flash_word,
    input  wire logic [5:0]  flash_rd_addr,
    input  wire logic        load_valid,
    input  wire logic [7:0]  load_result,
    input  wire logic        cpu_stall,
    input  wire logic        flash_erase,
    input  wire logic        flash_write,
    input  wire logic [15:0] flash_wr_data
);
    int          valid_cnt = 0;
    int          erase_cnt = 0;
    int          write_cnt = 0;
    int          stall_cnt = 0;
    logic [7:0]  last_byte = 8'h00;
    logic [15:0] wr_x      = 16'h0000;
    // already in programmed-reads-zero form, mixed bits so a swap shows
    assign fuses = '{lock_byte: 8'hFC, fuse_low: 8'h62, fuse_high: 8'hD9, fuse_ext: 8'hFD};
    // memory word is a pattern of its own address, so byte lanes differ
    assign flash_word = {2'h2, flash_rd_addr, 2'h1, flash_rd_addr};
    initial cpu_req = '0;
    always @(posedge clock) begin
        if (load_valid) begin
            valid_cnt++;
            last_byte = load_result;
        end
        erase_cnt += int'(flash_erase);
        if (flash_write) begin
            write_cnt++;
            wr_x ^= flash_wr_data;
        end
        stall_cnt += int'(cpu_stall);
    end
    // the pointer is set up ahead of a load, as software would, so the registered read address has caught up
    task automatic aim(input logic [15:0] z);
        cpu_req.zptr <= z;
    endtask
    // n extra edges after the bus release edge; each word loaded once per clear, same page for erase and write
    task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] d, input int n);
        repeat (n) @(posedge clock);
        cpu_req <= '{store: st, load: !st, zptr: z, data: d};
        @(posedge clock);
        cpu_req.store <= 1'b0;
        cpu_req.load  <= 1'b0;
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module tb
    import flash_prog_pkg::*;
;
    typedef struct {logic [4:0] code; logic [15:0] z; logic [7:0] exp;} row_type;
    logic         clock = 1'b0;
    logic         rst   = 1'b1;
    logic         cyc   = 1'b0;
    logic         stb   = 1'b0;
    logic         we    = 1'b0;
    logic         ee_busy = 1'b0;
    logic [3:0]   adr   = 4'h0;
    logic [3:0]   sel   = 4'h0;
    logic [31:0]  wdat  = 32'h0;
    logic [31:0]  rdat;
    logic         ack;
    cpu_req_type  cpu_req;
    fuse_set_type fuses;
    logic [15:0]  flash_word, wr_data;
    logic [7:0]   load_result, page;
    logic [5:0]   rd_addr, wr_word;
    logic         load_valid, cpu_stall, erase, write;
    int           error_cnt = 0;
    int           num_checks = 0;
    int           cycles = 0;
    int           s0;
    row_type      rows [6] = '{'{CMD_LREAD, Z_LOCK, 8'hFC}, '{CMD_LREAD, Z_FUSE_LOW, 8'h62},
        '{CMD_LREAD, Z_FUSE_HIGH, 8'hD9}, '{CMD_LREAD, Z_FUSE_EXT, 8'hFD},
        '{5'h00, 16'h0005, 8'h82}, '{5'h00, 16'h0004, 8'h42}};
    flash_self_program_control #(.WORD_BITS(6), .PAGE_BITS(8), .PROG_LEN(8)) i_dut (.clock(clock), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_req(cpu_req), .eeprom_write_busy_flag(ee_busy), .fuses(fuses),
        .flash_word(flash_word), .load_result(load_result), .load_valid(load_valid), .cpu_stall(cpu_stall),
        .flash_rd_addr(rd_addr), .flash_erase(erase), .flash_write(write), .flash_page(page),
        .flash_wr_data(wr_data), .flash_wr_word(wr_word));
    cpu_core_model i_cpu (.clock(clock), .cpu_req(cpu_req), .fuses(fuses), .flash_word(flash_word),
        .flash_rd_addr(rd_addr), .load_valid(load_valid), .load_result(load_result), .cpu_stall(cpu_stall),
        .flash_erase(erase), .flash_write(write), .flash_wr_data(wr_data));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic conclude();
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle: hold until ack is sampled, then release and idle one cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [4:0] code);
        logic [31:0] r;
        wb(1'b1, ADR_CTRL, {27'h0, code}, r);
    endtask
    task automatic rd_ctrl(input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, ADR_CTRL, 32'h0, r);
        check(r & m, exp);
    endtask
    task automatic settle();
        int n;
        n = 0;
        repeat (2) @(posedge clock);
        while (cpu_stall !== 1'b0 && n < 300) begin
            @(posedge clock);
            n++;
        end
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd_ctrl(32'hFF, 32'h0);
        foreach (rows[i]) begin
            i_cpu.aim(rows[i].z);
            wr(rows[i].code);
            i_cpu.issue(1'b0, rows[i].z, 16'h0, 0);
            repeat (3) @(posedge clock);
            check({i_cpu.last_byte, 24'(i_cpu.valid_cnt)}, {rows[i].exp, 24'(i + 1)});
            rd_ctrl(32'h1F, 32'h0);
        end
        wr(5'h07);
        rd_ctrl(32'h1F, 32'h0);
        wr(CMD_WRITE);
        rd_ctrl(32'h1F, {27'h0, CMD_WRITE});
        repeat (4) @(posedge clock);
        rd_ctrl(32'h1F, 32'h0);
        i_cpu.aim(Z_LOCK);
        wr(CMD_LREAD);
        i_cpu.issue(1'b0, Z_LOCK, 16'h0, 2);
        repeat (2) @(posedge clock);
        check({i_cpu.last_byte, 24'(i_cpu.valid_cnt)}, {8'h80, 24'd7});
        wr(CMD_ERASE);
        i_cpu.issue(1'b1, 16'h0280, 16'h0, 3);
        check(32'(i_cpu.erase_cnt), 32'd0);
        wr(CMD_LOAD);
        i_cpu.issue(1'b1, 16'h0286, 16'h1234, 1);
        wr(CMD_LOAD);
        i_cpu.issue(1'b1, 16'h0282, 16'hBEEF, 0);
        s0 = i_cpu.stall_cnt;
        wr(CMD_ERASE);
        i_cpu.issue(1'b1, 16'h82D5, 16'hFFFF, 0);
        settle();
        check({page, 24'(i_cpu.stall_cnt - s0)}, {8'h05, 24'd8});
        check(32'(i_cpu.erase_cnt), 32'd1);
        wr(CMD_WRITE);
        i_cpu.issue(1'b1, 16'h0280, 16'h0, 0);
        rd_ctrl(32'h01, 32'h1);
        settle();
        check({i_cpu.wr_x, 16'(i_cpu.write_cnt)}, {16'h1234 ^ 16'hBEEF, 16'd2});
        rd_ctrl(32'h1F, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(CMD_LOAD);
            i_cpu.issue(1'b1, 16'h0284, 16'h5A5A, 0);
            if (k == 0) wr(CMD_SRE);
            else begin
                ee_busy <= 1'b1;
                repeat (3) @(posedge clock);
                if (k == 2) wr(CMD_ERASE);
                if (k == 2) rd_ctrl(32'h1F, 32'h0);
                ee_busy <= 1'b0;
                @(posedge clock);
            end
            wr(CMD_WRITE);
            i_cpu.issue(1'b1, 16'h0280, 16'h0, 0);
            settle();
            check(32'(i_cpu.write_cnt), 32'd2);
        end
        conclude();
    end
endmodule
